// [aarc_pkg.sv]
// aarc_pkg: constants and types for the converter alarm and reference control block
// assumes an 8-bit register port and a single 200 MHz clock
package aarc_pkg;
    localparam int AW = 4;
    localparam int DW = 8;

    // register offsets
    localparam logic [3:0] A_FIRST_MODE_REG   = 4'h0;
    localparam logic [3:0] A_REFSEL1 = 4'h1;
    localparam logic [3:0] A_REFSEL2 = 4'h2;
    localparam logic [3:0] A_REFCTL  = 4'h3;
    localparam logic [3:0] A_STATUS  = 4'h4;
    localparam logic [3:0] A_IRQSTAT = 4'h5;
    localparam logic [3:0] A_IRQMASK = 4'h6;

    // field positions
    localparam int REV_BIT   = 7;
    localparam int POS_LSB   = 3;
    localparam int NEG_LSB   = 0;
    localparam int INTEN_BIT = 0;
    localparam int DONE_BIT  = 0;
    localparam int DIFF_BIT  = 1;
    localparam int HIGH_BIT  = 2;
    localparam int LOW_BIT   = 3;
    localparam int LREF_BIT  = 4;
    localparam int NALARM    = 4;

    // reset values
    localparam logic [2:0] SEL_INTERNAL = 3'h0;
    localparam logic       INTEN_RST    = 1'b1;
    localparam logic       REV_RST      = 1'b0;
    localparam logic [7:0] MASK_RST     = 8'h00;

    typedef struct packed {
        logic low_reference_alarm;
        logic amp_output_low_alarm;
        logic amp_output_high_alarm;
        logic diff_overrange_alarm;
    } aarc_alarm_s;

    typedef struct packed {
        logic [2:0] ref_pos_select;
        logic [2:0] ref_neg_select;
    } aarc_refsel_s;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'b01,
        CONV_RUN  = 2'b10
    } aarc_conv_e;
endpackage

// [aarc_ctrl.sv]
// aarc_ctrl: per-conversion alarm capture and reference multiplexer control
// assumes comparator levels are asynchronous, conversion strobes come from
// the converter sequencer on CLOCK, and registers sit on a plain strobe port
// Functional notes
// - differential overrange sets its flag only while a conversion runs.
// - the differential flag clears for the next conversion and stays clear if in range.
// - amplifier-high flag sets when either output nears the positive supply.
// - amplifier-low flag sets when either output nears the negative supply.
// - high and low flags report in their own conversion and clear for the next one.
// - low-reference alarm is watched all conversion long and sits at status bit 4.
// - two 3-bit reference select fields, positive and negative.
// - both fields zero routes the internal 2.5 V reference to the primary converter.
// - internal reference is powered while its enable is 1, on after reset.
// - mode bit 7 reverses the primary reference polarity, never the secondary.
// - reset selects the internal reference for both converters, kept separately.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module aarc_ctrl
    import aarc_pkg::*;
(
    // clock and reset
    input  wire logic                  CLOCK,
    input  wire logic                  RESET,
    input  wire logic                  CE,
    // register port
    input  wire logic [aarc_pkg::AW-1:0] ADDR,
    input  wire logic [aarc_pkg::DW-1:0] WDATA,
    input  wire logic                  WR,
    input  wire logic                  RD,
    output logic [aarc_pkg::DW-1:0]    RDATA,
    // comparator levels, asynchronous
    input  wire logic                  CMP_DIFF_OVR,
    input  wire logic                  CMP_AMP_HIGH,
    input  wire logic                  CMP_AMP_LOW,
    input  wire logic                  CMP_LOW_REF,
    // conversion sequencer
    input  wire logic                  CONV_START,
    input  wire logic                  CONV_DONE,
    // status byte to the data path
    output logic [aarc_pkg::DW-1:0]    STATUS_BYTE,
    output logic                       STATUS_VALID,
    // reference control
    output aarc_pkg::aarc_refsel_s     PRI_REF_SEL,
    output aarc_pkg::aarc_refsel_s     SEC_REF_SEL,
    output logic                       PRI_USE_INT_REF,
    output logic                       SEC_USE_INT_REF,
    output logic                       INT_REF_ENABLE,
    output logic                       PRI_REF_REVERSE,
    // interrupt
    output logic                       IRQ
);
    import aarc_pkg::*;

    // comparator synchronisers and accumulators
    logic [NALARM-1:0] cmp_in;
    logic [NALARM-1:0] sync1_q;
    logic [NALARM-1:0] sync2_q;
    logic [NALARM-1:0] acc_q;
    logic [NALARM-1:0] acc_final;

    aarc_conv_e        state_q;
    aarc_conv_e        state_d;
    aarc_alarm_s       alarms_q;

    aarc_refsel_s      pri_sel_q;
    aarc_refsel_s      sec_sel_q;
    logic              rev_q;
    logic              inten_q;
    logic [DW-1:0]     irq_stat_q;
    logic [DW-1:0]     irq_mask_q;
    logic [DW-1:0]     irq_stat_d;

    logic [DW-1:0]     status_byte_q;
    logic              status_valid_q;
    logic [DW-1:0]     rdata_q;
    logic              irq_q;
    logic              pri_int_q;
    logic              sec_int_q;

    // decode
    wire running    = (state_q == CONV_RUN);
    wire wr_mode    = WR && (ADDR == A_FIRST_MODE_REG);
    wire wr_refsel1 = WR && (ADDR == A_REFSEL1);
    wire wr_refsel2 = WR && (ADDR == A_REFSEL2);
    wire wr_refctl  = WR && (ADDR == A_REFCTL);
    wire wr_irqstat = WR && (ADDR == A_IRQSTAT);
    wire wr_irqmask = WR && (ADDR == A_IRQMASK);
    wire conv_end   = CONV_DONE && running;

    assign cmp_in = {CMP_LOW_REF, CMP_AMP_LOW, CMP_AMP_HIGH, CMP_DIFF_OVR};

    // the level seen in the final cycle still counts toward this conversion
    assign acc_final = acc_q | (sync2_q & {NALARM{running}});

    wire [DW-1:0] status_next = {3'h0, acc_final, 1'b0};

    // events: conversion done plus each alarm as captured
    wire [DW-1:0] irq_events = conv_end ? (status_next | 8'h01) : 8'h00;

    // set wins over a same-cycle write-one-to-clear
    assign irq_stat_d = (wr_irqstat ? (irq_stat_q & ~WDATA) : irq_stat_q) | irq_events;

    // a start while running restarts the conversion
    always_comb begin
        state_d = state_q;
        case (state_q)
            CONV_IDLE: if (CONV_START) state_d = CONV_RUN;
            CONV_RUN:  if (CONV_DONE && !CONV_START) state_d = CONV_IDLE;
            default:   state_d = CONV_IDLE;
        endcase
    end

    wire [DW-1:0] rd_mux =
        (ADDR == A_FIRST_MODE_REG)   ? {rev_q, 7'h00} :
        (ADDR == A_REFSEL1) ? {2'h0, pri_sel_q} :
        (ADDR == A_REFSEL2) ? {2'h0, sec_sel_q} :
        (ADDR == A_REFCTL)  ? {7'h00, inten_q} :
        (ADDR == A_STATUS)  ? status_byte_q :
        (ADDR == A_IRQSTAT) ? irq_stat_q :
        (ADDR == A_IRQMASK) ? irq_mask_q : 8'h00;

    // per-alarm synchroniser and sticky accumulator
    genvar gi;
    generate
        for (gi = 0; gi < NALARM; gi++) begin : g_alarm
            always_ff @(posedge CLOCK) begin
                if (RESET) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    acc_q[gi]   <= 1'b0;
                end else if (CE) begin
                    sync1_q[gi] <= cmp_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    if (CONV_START || conv_end) begin
                        acc_q[gi] <= 1'b0;
                    end else if (running && sync2_q[gi]) begin
                        acc_q[gi] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // conversion state and status byte
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            state_q        <= CONV_IDLE;
            status_byte_q  <= 8'h00;
            status_valid_q <= 1'b0;
            alarms_q       <= '0;
        end else if (CE) begin
            state_q        <= state_d;
            status_valid_q <= conv_end;
            if (conv_end) begin
                status_byte_q <= status_next;
                alarms_q      <= acc_final;
            end
        end
    end

    // reference controls
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            pri_sel_q <= {SEL_INTERNAL, SEL_INTERNAL};
            sec_sel_q <= {SEL_INTERNAL, SEL_INTERNAL};
            inten_q   <= INTEN_RST;
            rev_q     <= REV_RST;
        end else if (CE) begin
            if (wr_refsel1) pri_sel_q <= WDATA[5:0];
            if (wr_refsel2) sec_sel_q <= WDATA[5:0];
            if (wr_refctl)  inten_q   <= WDATA[INTEN_BIT];
            if (wr_mode)    rev_q     <= WDATA[REV_BIT];
        end
    end

    // registered reference outputs
    // reversal is not blocked for internal or supply selects: the host owns that
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            pri_int_q <= 1'b1;
            sec_int_q <= 1'b1;
        end else if (CE) begin
            pri_int_q <= (pri_sel_q == '0);
            sec_int_q <= (sec_sel_q == '0);
        end
    end

    // interrupt and read port
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            irq_stat_q <= 8'h00;
            irq_mask_q <= MASK_RST;
            irq_q      <= 1'b0;
            rdata_q    <= 8'h00;
        end else if (CE) begin
            irq_stat_q <= irq_stat_d;
            if (wr_irqmask) irq_mask_q <= WDATA;
            irq_q      <= |(irq_stat_q & irq_mask_q);
            rdata_q    <= RD ? rd_mux : 8'h00;
        end
    end

    assign RDATA           = rdata_q;
    assign STATUS_BYTE     = status_byte_q;
    assign STATUS_VALID    = status_valid_q;
    assign PRI_REF_SEL     = pri_sel_q;
    assign SEC_REF_SEL     = sec_sel_q;
    assign PRI_USE_INT_REF = pri_int_q;
    assign SEC_USE_INT_REF = sec_int_q;
    assign INT_REF_ENABLE  = inten_q;
    assign PRI_REF_REVERSE = rev_q;
    assign IRQ             = irq_q;
endmodule

// [aarc_host.sv]
// aarc_host: host side collecting the status byte sent with each conversion
// assumes STATUS_VALID is a one-cycle pulse on CLOCK
`timescale 1ns/1ps
module aarc_host
    import aarc_pkg::*;
(
    // clock
    input  wire logic                    CLOCK,
    // status stream
    input  wire logic [aarc_pkg::DW-1:0] STATUS_BYTE,
    input  wire logic                    STATUS_VALID,
    // collected result
    output logic [aarc_pkg::DW-1:0]      LAST_STATUS,
    output int                           N_STATUS
);
    initial begin
        LAST_STATUS = 8'h00;
        N_STATUS = 0;
    end
    // pulse is one cycle only, so sample on the very next edge
    always @(posedge CLOCK) begin
        if (STATUS_VALID) begin
            LAST_STATUS <= STATUS_BYTE;
            N_STATUS <= N_STATUS + 1;
        end
    end
endmodule

// [aarc_ctrl_props.sv]
// aarc_ctrl_props: port-level checks on alarm capture and reference control
// assumes it is bound onto aarc_ctrl, one clock, synchronous reset
`timescale 1ns/1ps
module aarc_ctrl_props
    import aarc_pkg::*;
(
    // clock and reset
    input wire logic                    CLOCK,
    input wire logic                    RESET,
    input wire logic                    CE,
    // register port
    input wire logic [aarc_pkg::AW-1:0] ADDR,
    input wire logic [aarc_pkg::DW-1:0] WDATA,
    input wire logic                    WR,
    input wire logic                    RD,
    input wire logic [aarc_pkg::DW-1:0] RDATA,
    // conversion and status
    input wire logic                    CONV_DONE,
    input wire logic [aarc_pkg::DW-1:0] STATUS_BYTE,
    input wire logic                    STATUS_VALID,
    // reference control
    input wire aarc_pkg::aarc_refsel_s  PRI_REF_SEL,
    input wire aarc_pkg::aarc_refsel_s  SEC_REF_SEL,
    input wire logic                    PRI_USE_INT_REF,
    input wire logic                    INT_REF_ENABLE,
    input wire logic                    PRI_REF_REVERSE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    a_status_spare_zero: assert property (STATUS_VALID |-> STATUS_BYTE[7:5] == 3'h0 && !STATUS_BYTE[0])
        else $error("status spare bits set");
    a_valid_after_done: assert property (STATUS_VALID |-> $past(CONV_DONE))
        else $error("status valid without done");
    a_valid_single_pulse: assert property (STATUS_VALID |=> !STATUS_VALID)
        else $error("status valid longer than one cycle");
    a_pri_sel_write: assert property (CE && WR && ADDR == A_REFSEL1 |=> PRI_REF_SEL == $past(WDATA[5:0]))
        else $error("primary select not written");
    a_sec_sel_write: assert property (CE && WR && ADDR == A_REFSEL2 |=> SEC_REF_SEL == $past(WDATA[5:0]))
        else $error("secondary select not written");
    a_int_ref_route: assert property (CE |=> PRI_USE_INT_REF == ($past(PRI_REF_SEL) == 6'h00))
        else $error("internal route flag wrong");
    a_int_en_write: assert property (CE && WR && ADDR == A_REFCTL |=> INT_REF_ENABLE == $past(WDATA[0]))
        else $error("internal reference enable not written");
    a_reverse_write: assert property (CE && WR && ADDR == A_FIRST_MODE_REG |=> PRI_REF_REVERSE == $past(WDATA[7]))
        else $error("reversal bit not written");
    a_rdata_idle_zero: assert property (CE && !RD |=> RDATA == 8'h00)
        else $error("read data outside read cycle");
endmodule

// [aarc_ctrl_test.sv]
// aarc_ctrl_test: random and corner tests of alarm capture and reference control
// assumes aarc_ctrl, aarc_host and aarc_ctrl_props are compiled first
`timescale 1ns/1ps
module aarc_ctrl_test;
    import aarc_pkg::*;
    localparam int STARTUP = 20; // short stand-in for reference settling
    logic         CLOCK = 0, RESET = 1, CE = 1, WR = 0, RD = 0, CONV_START = 0, CONV_DONE = 0;
    logic         CMP_DIFF_OVR = 0, CMP_AMP_HIGH = 0, CMP_AMP_LOW = 0, CMP_LOW_REF = 0;
    logic [3:0]   ADDR = 4'h0, a;
    logic [7:0]   WDATA = 8'h00, RDATA, STATUS_BYTE, last, d, msk;
    logic         STATUS_VALID, PRI_USE_INT_REF, SEC_USE_INT_REF, INT_REF_ENABLE, PRI_REF_REVERSE, IRQ;
    logic [5:0]   ps, ss;
    aarc_refsel_s PRI_REF_SEL, SEC_REF_SEL;
    int           n_errors = 0, samples_checked = 0, cyc = 0, nst;
    aarc_ctrl dut (.*);
    aarc_host host (.CLOCK(CLOCK), .STATUS_BYTE(STATUS_BYTE), .STATUS_VALID(STATUS_VALID),
        .LAST_STATUS(last), .N_STATUS(nst));
    always #2.5 CLOCK = ~CLOCK;
    function automatic logic [7:0] exp_st(logic [3:0] al);
        return {3'h0, al, 1'b0};
    endfunction
    task chk(string nm, logic [7:0] e, logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(logic [3:0] ad, logic [7:0] dt);
        @(posedge CLOCK);
        WR <= 1'b1; ADDR <= ad; WDATA <= dt;
        @(posedge CLOCK) WR <= 1'b0;
    endtask
    task rd(logic [3:0] ad, output logic [7:0] dt);
        @(posedge CLOCK);
        RD <= 1'b1; ADDR <= ad;
        @(posedge CLOCK) RD <= 1'b0;
        @(negedge CLOCK) dt = RDATA;
    endtask
    task conclude();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // cut a hang short, about seven times the expected run
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_errors++;
            conclude();
        end
    end
    bit [7:0] fl;
    initial begin
        void'($urandom(75382));
        repeat (12) @(posedge CLOCK);
        RESET <= 1'b0;
        @(negedge CLOCK);
        chk("pri_sel", 8'h00, PRI_REF_SEL);
        chk("sec_sel", 8'h00, SEC_REF_SEL);
        fl = {3'h0, PRI_REF_REVERSE, IRQ, INT_REF_ENABLE, PRI_USE_INT_REF, SEC_USE_INT_REF};
        chk("ref_flags", 8'h07, fl);
        for (int i = 0; i < 8; i++) begin
            ps = (i == 7) ? 6'h00 : 6'($urandom);
            ss = (i == 7) ? 6'h00 : 6'($urandom);
            wr(A_REFSEL1, {2'h0, ps});
            wr(A_REFSEL2, {2'h0, ss});
            // reversal only with external pairs, never internal or supply
            wr(A_FIRST_MODE_REG, {ps[5:3] inside {[1:3]} && ps[2:0] inside {[1:3]}, 7'h00});
            rd(A_REFSEL2, d);
            chk("sec_read", {2'h0, ss}, d);
            chk("sec_sel", {2'h0, ss}, SEC_REF_SEL);
            chk("sec_int", {7'h0, ss == 6'h00}, SEC_USE_INT_REF);
            chk("pri_sel", {2'h0, ps}, PRI_REF_SEL);
            chk("pri_int", {7'h0, ps == 6'h00}, PRI_USE_INT_REF);
            chk("reverse", {7'h0, ps[5:3] inside {[1:3]} && ps[2:0] inside {[1:3]}}, PRI_REF_REVERSE);
            rd(4'h7 + 4'(i), d);
            chk("unmapped", 8'h00, d);
        end
        wr(A_REFCTL, 8'h00);
        rd(A_REFCTL, d);
        chk("int_en", 8'h00, {7'h0, INT_REF_ENABLE});
        // clock enable low: a write to the reference control must leave the internal reference enable as it was
        CE <= 1'b0;
        wr(A_REFCTL, 8'h01);
        CE <= 1'b1;
        @(negedge CLOCK);
        chk("ce_freeze", 8'h00, {7'h0, INT_REF_ENABLE});
        wr(A_REFCTL, 8'h01);
        repeat (STARTUP) @(posedge CLOCK);
        for (int j = 0; j < 24; j++) begin
            a = (j < 4) ? 4'h1 << j : (j < 6) ? 4'h0 : 4'($urandom);
            msk = j[0] ? 8'h1F : 8'h00;
            wr(A_IRQMASK, msk);
            {CMP_LOW_REF, CMP_AMP_LOW, CMP_AMP_HIGH, CMP_DIFF_OVR} <= 4'hF;
            repeat (3) @(posedge CLOCK);
            {CMP_LOW_REF, CMP_AMP_LOW, CMP_AMP_HIGH, CMP_DIFF_OVR} <= 4'h0;
            repeat (3) @(posedge CLOCK);
            CONV_START <= 1'b1;
            @(posedge CLOCK) CONV_START <= 1'b0;
            {CMP_LOW_REF, CMP_AMP_LOW, CMP_AMP_HIGH, CMP_DIFF_OVR} <= (j == 5) ? 4'hF : a;
            repeat (3) @(posedge CLOCK);
            {CMP_LOW_REF, CMP_AMP_LOW, CMP_AMP_HIGH, CMP_DIFF_OVR} <= 4'h0;
            repeat (4) @(posedge CLOCK);
            // restart mid-run drops what was gathered so far
            if (j == 5) CONV_START <= 1'b1;
            @(posedge CLOCK) CONV_START <= 1'b0;
            repeat (3) @(posedge CLOCK);
            CONV_DONE <= 1'b1;
            @(posedge CLOCK) CONV_DONE <= 1'b0;
            @(posedge CLOCK);
            @(negedge CLOCK);
            chk("status", exp_st(a), STATUS_BYTE);
            chk("host_status", exp_st(a), last);
            chk("host_count", 8'(j + 1), 8'(nst));
            chk("irq", {7'h0, msk != 8'h00}, {7'h0, IRQ});
            rd(A_IRQSTAT, d);
            chk("irq_stat", exp_st(a) | 8'h01, d);
            rd(A_STATUS, d);
            chk("status_read", exp_st(a), d);
            wr(A_IRQSTAT, 8'hFF);
            repeat (2) @(posedge CLOCK);
            @(negedge CLOCK);
            chk("irq_clear", 8'h00, {7'h0, IRQ});
        end
        conclude();
    end
endmodule
bind aarc_ctrl aarc_ctrl_props u_props (.*);
